// [hw/tmw_pkg.sv]
// Package: register offsets, control fields and constants for the wide timer.
package tmw_pkg;
  // ==========================================================
  // Register addresses on the 8-bit I/O bus
  localparam logic [7:0] ADDR_CAPTURE_LOW = 8'h1f;
  localparam logic [7:0] ADDR_CAPTURE_HIGH = 8'h20;
  localparam logic [7:0] ADDR_COMPARE_FIRST = 8'h21;
  localparam logic [7:0] ADDR_COMPARE_SECOND = 8'h22;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h23;
  localparam logic [7:0] ADDR_CONTROL = 8'h24;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h25;
  localparam logic [7:0] ADDR_FLAGS = 8'h27;
  // ==========================================================
  // Control register fields
  localparam int CTRL_WIDTH_BIT = 7;
  localparam int CTRL_CAPTURE_EN_BIT = 6;
  localparam int CTRL_FILTER_BIT = 5;
  localparam int CTRL_EDGE_BIT = 4;
  localparam int CTRL_CLEAR_BIT = 3;
  localparam int CTRL_CLOCK_MSB = 2;
  // Flag register fields
  localparam int FLAG_CAPTURE_BIT = 7;
  localparam int FLAG_COMPARE_SECOND_BIT = 5;
  localparam int FLAG_COMPARE_FIRST_BIT = 4;
  localparam int FLAG_OVERFLOW_BIT = 3;
  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] MAX_WIDE = 16'hffff;
  localparam logic [7:0] MAX_NARROW = 8'hff;
  localparam logic [1:0] FILTER_SAMPLES_M1 = 2'h3;
  localparam logic [9:0] PRESCALE_RESET = 10'h000;
  // ==========================================================
  // Clock source selection
  typedef enum logic [2:0] {
    TMW_CLK_STOP = 3'h0,
    TMW_CLK_DIV1 = 3'h1,
    TMW_CLK_DIV8 = 3'h2,
    TMW_CLK_DIV64 = 3'h3,
    TMW_CLK_DIV256 = 3'h4,
    TMW_CLK_DIV1024 = 3'h5,
    TMW_CLK_EXT_FALL = 3'h6,
    TMW_CLK_EXT_RISE = 3'h7
  } tmw_clock_type;
endpackage

// [hw/tmw_timer.sv]
// Wide-access timer/counter with shared high-byte staging latch.
// Operation
// R1 - Only low-byte accesses start a wide transfer; high-byte alone touches latch.
// R2 - Low-byte write loads latch high byte and written low byte together.
// R3 - Low-byte read copies register high byte into latch same cycle.
// R4 - One staging latch shared by all wide registers.
// R5 - Compare halves read directly without touching latch outside capture mode.
// R6 - In 16-bit capture mode capture register goes through the latch.
// R7 - CPU writes high before low, reads low before high.
// R8 - Main code masks interrupts around two-byte accesses.
// R9 - One high byte write may serve several low-byte writes.
// R10 - Width bit selects 16-bit counting and joined compare value.
// R11 - Capture enable bit selects input capture mode.
// R12 - Filter needs four equal samples before output changes.
// R13 - Edge bit: zero falling, one rising capture trigger.
// R14 - Qualified edge copies counter to capture register and sets capture flag.
// R15 - Clear bit picks free running or clear on first compare match; the code ignores the clear bit in 16-bit mode.
// R16 - Clock select 000 stop, 001 direct, 010-101 prescaled by 8..1024.
// R17 - Clock select 110 falling, 111 rising external pin edges.
// R18 - External pin edges count even when that pin is an output.
// R19 - Counter low-byte write blocks compare match on next tick.
// R20 - Count low byte is direct counter access, low half in wide mode.
// R21 - Clear mode resets counter to zero on first compare match; the code does this only while the width bit is zero.
// R22 - Overflow flag set in the tick the counter wraps from max.
// R23 - Counter increments per selected tick, holds when no source.
`timescale 1ns/10ps
module tmw_timer (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] bus_addr_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic bus_write_in,
  input wire logic bus_read_in,
  input wire logic capture_input_pin_in,
  input wire logic external_count_pin_in,
  output logic [7:0] bus_rdata_out,
  output logic capture_flag_out,
  output logic overflow_flag_out,
  output logic compare_first_flag_out,
  output logic compare_second_flag_out,
  output logic [15:0] count_out
);
  import tmw_pkg::*;

  // ==========================================================
  // Registers
  logic [7:0] control;
  logic [7:0] staging;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] compare_value_first;
  logic [7:0] compare_value_second;
  logic [9:0] prescale;
  logic ext_prev;
  logic block_match;
  logic [1:0] filter_count;
  logic filter_value;
  logic capture_raw_prev;
  logic capture_prev;

  logic width_select;
  logic capture_mode_enable;
  logic capture_filter_enable;
  logic capture_edge_select;
  logic clear_on_match_select;
  tmw_clock_type clock_source_select;
  assign width_select = control[CTRL_WIDTH_BIT]; // R10
  assign capture_mode_enable = control[CTRL_CAPTURE_EN_BIT]; // R11
  assign capture_filter_enable = control[CTRL_FILTER_BIT];
  assign capture_edge_select = control[CTRL_EDGE_BIT];
  assign clear_on_match_select = control[CTRL_CLEAR_BIT];
  assign clock_source_select = tmw_clock_type'(control[CTRL_CLOCK_MSB:0]);

  // ==========================================================
  // Bus decode
  logic wr_ctrl, wr_cnt_lo, wr_cnt_hi, wr_cmp_a, wr_cmp_b, wr_flags;
  logic rd_cnt_lo, rd_cap_lo;
  logic wr_cap_lo, wr_cap_hi;
  assign wr_ctrl = bus_write_in && bus_addr_in == ADDR_CONTROL;
  assign wr_cnt_lo = bus_write_in && bus_addr_in == ADDR_COUNT_LOW;
  assign wr_cnt_hi = bus_write_in && bus_addr_in == ADDR_COUNT_HIGH;
  assign wr_cmp_a = bus_write_in && bus_addr_in == ADDR_COMPARE_FIRST;
  assign wr_cmp_b = bus_write_in && bus_addr_in == ADDR_COMPARE_SECOND;
  assign wr_flags = bus_write_in && bus_addr_in == ADDR_FLAGS;
  assign wr_cap_lo = bus_write_in && bus_addr_in == ADDR_CAPTURE_LOW;
  assign wr_cap_hi = bus_write_in && bus_addr_in == ADDR_CAPTURE_HIGH;
  assign rd_cnt_lo = bus_read_in && bus_addr_in == ADDR_COUNT_LOW;
  assign rd_cap_lo = bus_read_in && bus_addr_in == ADDR_CAPTURE_LOW;

  // ==========================================================
  // Tick generation
  logic tick;
  logic ext_fall, ext_rise;
  // Pin is sampled as is; direction of the pad does not matter
  assign ext_fall = ext_prev && !external_count_pin_in; // R18
  assign ext_rise = !ext_prev && external_count_pin_in; // R18
  always_comb begin
    case (clock_source_select) // R16 R17
      TMW_CLK_STOP: tick = 1'b0;
      TMW_CLK_DIV1: tick = 1'b1;
      TMW_CLK_DIV8: tick = prescale[2:0] == 3'h7;
      TMW_CLK_DIV64: tick = prescale[5:0] == 6'h3f;
      TMW_CLK_DIV256: tick = prescale[7:0] == 8'hff;
      TMW_CLK_DIV1024: tick = prescale == 10'h3ff;
      TMW_CLK_EXT_FALL: tick = ext_fall;
      TMW_CLK_EXT_RISE: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  // Prescaler runs free so its phase is independent of clock select
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      prescale <= PRESCALE_RESET;
      ext_prev <= 1'b0;
    end else begin
      prescale <= prescale + 10'h001;
      ext_prev <= external_count_pin_in;
    end
  end

  // ==========================================================
  // Compare and counting
  logic [15:0] count;
  logic [15:0] compare_word;
  logic [15:0] count_max;
  logic match_first, match_second, at_max;
  logic [15:0] next_count;
  assign count = {width_select ? count_high_byte : RESET_BYTE, count_low_byte};
  assign compare_word = width_select ? {compare_value_second, compare_value_first} // R10
                                     : {RESET_BYTE, compare_value_first};
  assign count_max = width_select ? MAX_WIDE : {RESET_BYTE, MAX_NARROW};
  assign match_first = !capture_mode_enable && count == compare_word;
  assign match_second = !capture_mode_enable && !width_select
                        && count_low_byte == compare_value_second;
  assign at_max = count == count_max;

  always_comb begin
    next_count = count;
    if (tick) begin // R23
      if (clear_on_match_select && !width_select && match_first && !block_match) begin
        next_count = RESET_WORD; // R21 R15
      end else if (at_max) begin
        next_count = RESET_WORD;
      end else begin
        next_count = count + 16'h0001;
      end
    end
  end

  // Block flag lasts until the next tick, also while stopped
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      block_match <= 1'b0;
    end else if (wr_cnt_lo || wr_cnt_hi) begin
      block_match <= 1'b1; // R19
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  // ==========================================================
  // Capture input filter and edge detection
  logic cap_src, cap_edge;
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      capture_raw_prev <= 1'b0;
      filter_count <= 2'h0;
      filter_value <= 1'b0;
      capture_prev <= 1'b0;
    end else begin
      capture_raw_prev <= capture_input_pin_in;
      if (capture_input_pin_in != capture_raw_prev || capture_input_pin_in == filter_value) begin
        filter_count <= 2'h0;
      end else if (filter_count == FILTER_SAMPLES_M1 - 2'h1) begin
        filter_value <= capture_input_pin_in; // R12
        filter_count <= 2'h0;
      end else begin
        filter_count <= filter_count + 2'h1;
      end
      capture_prev <= cap_src;
    end
  end
  assign cap_src = capture_filter_enable ? filter_value : capture_raw_prev;
  assign cap_edge = capture_mode_enable
                    && (capture_edge_select ? (cap_src && !capture_prev) // R13
                                            : (!cap_src && capture_prev));

  // ==========================================================
  // Register file, staging latch and counter
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      control <= RESET_BYTE;
    end else if (wr_ctrl) begin
      control <= bus_wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      staging <= RESET_BYTE;
    end else if (wr_cnt_hi || wr_cap_hi) begin
      staging <= bus_wdata_in; // R1 R4 R9
    end else if (wr_cmp_b && width_select && !capture_mode_enable) begin
      staging <= bus_wdata_in; // R1
    end else if (rd_cnt_lo) begin
      staging <= count_high_byte; // R3
    end else if (rd_cap_lo && width_select && capture_mode_enable) begin
      staging <= compare_value_second; // R6 R3
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      count_low_byte <= RESET_BYTE;
      count_high_byte <= RESET_BYTE;
    end else if (wr_cnt_lo) begin
      count_low_byte <= bus_wdata_in; // R20 R2
      if (width_select) begin
        count_high_byte <= staging; // R2
      end
    end else begin
      count_low_byte <= next_count[7:0];
      count_high_byte <= width_select ? next_count[15:8] : count_high_byte;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      compare_value_first <= RESET_BYTE;
      compare_value_second <= RESET_BYTE;
    end else if (cap_edge) begin
      compare_value_first <= count_low_byte; // R14
      if (width_select) begin
        compare_value_second <= count_high_byte; // R14
      end
    end else if (wr_cap_lo && width_select && capture_mode_enable) begin
      compare_value_first <= bus_wdata_in; // R6
      compare_value_second <= staging; // R6
    end else if (wr_cmp_a) begin
      compare_value_first <= bus_wdata_in;
      if (width_select && !capture_mode_enable) begin
        compare_value_second <= staging; // R2
      end
    end else if (wr_cmp_b && !width_select) begin
      compare_value_second <= bus_wdata_in;
    end
  end

  // ==========================================================
  // Flags: set wins over write-one clear
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      capture_flag_out <= 1'b0;
      overflow_flag_out <= 1'b0;
      compare_first_flag_out <= 1'b0;
      compare_second_flag_out <= 1'b0;
    end else begin
      if (cap_edge) begin
        capture_flag_out <= 1'b1; // R14
      end else if (wr_flags && bus_wdata_in[FLAG_CAPTURE_BIT]) begin
        capture_flag_out <= 1'b0;
      end
      if (tick && at_max && !wr_cnt_lo) begin
        overflow_flag_out <= 1'b1; // R22
      end else if (wr_flags && bus_wdata_in[FLAG_OVERFLOW_BIT]) begin
        overflow_flag_out <= 1'b0;
      end
      if (tick && match_first && !block_match) begin
        compare_first_flag_out <= 1'b1; // R19
      end else if (wr_flags && bus_wdata_in[FLAG_COMPARE_FIRST_BIT]) begin
        compare_first_flag_out <= 1'b0;
      end
      if (tick && match_second && !block_match) begin
        compare_second_flag_out <= 1'b1;
      end else if (wr_flags && bus_wdata_in[FLAG_COMPARE_SECOND_BIT]) begin
        compare_second_flag_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read data, registered one cycle after the read strobe
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = RESET_BYTE;
    case (bus_addr_in)
      ADDR_CONTROL: next_rdata = control;
      ADDR_COUNT_LOW: next_rdata = count_low_byte;
      ADDR_COUNT_HIGH: next_rdata = staging; // R1
      ADDR_COMPARE_FIRST: next_rdata = compare_value_first; // R5
      ADDR_COMPARE_SECOND: next_rdata = compare_value_second; // R5
      ADDR_CAPTURE_LOW: next_rdata = compare_value_first;
      ADDR_CAPTURE_HIGH: next_rdata = width_select && capture_mode_enable ? staging
                                                                          : compare_value_second;
      ADDR_FLAGS: next_rdata = {capture_flag_out, 1'b0, compare_second_flag_out,
                                compare_first_flag_out, overflow_flag_out, 3'h0};
      default: next_rdata = RESET_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      bus_rdata_out <= RESET_BYTE;
      count_out <= RESET_WORD;
    end else begin
      bus_rdata_out <= bus_read_in ? next_rdata : RESET_BYTE;
      count_out <= count;
    end
  end
endmodule

// [test/timer1_wide_access_and_control_tb_top.sv]
// Top testbench: drives the wide timer through the CPU bus model.
`timescale 1ns/10ps
module timer1_wide_access_and_control_tb_top;
  import tmw_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic cap_pin = 1'b0;
  logic ext_pin = 1'b0;
  logic [7:0] addr, wdata, rdata, b;
  logic wr_s, rd_s, cap_f, ovf_f, cmp1_f, cmp2_f;
  logic [15:0] count, q;
  int errors = 0;
  int n_compared = 0;
  int k;
  int div [6] = '{0, 1, 8, 64, 256, 1024};
  always #4 sys_clk_in = ~sys_clk_in;
  tmw_timer u_tmw_timer (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .bus_addr_in(addr),
    .bus_wdata_in(wdata), .bus_write_in(wr_s), .bus_read_in(rd_s),
    .capture_input_pin_in(cap_pin), .external_count_pin_in(ext_pin), .bus_rdata_out(rdata),
    .capture_flag_out(cap_f), .overflow_flag_out(ovf_f), .compare_first_flag_out(cmp1_f),
    .compare_second_flag_out(cmp2_f), .count_out(count));
  tmw_cpu_model u_tmw_cpu_model (.sys_clk_in(sys_clk_in), .bus_rdata_in(rdata),
    .bus_addr_out(addr), .bus_wdata_out(wdata), .bus_write_out(wr_s), .bus_read_out(rd_s));
  // ==========================================================
  // Shared tasks
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  task automatic check(input logic [15:0] act, input logic [15:0] exp);
    n_compared++;
    if (act !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    errors++;
    report_and_stop();
  end
  // ==========================================================
  // Test sequence
  initial begin
    cyc(2);
    reset_in = 1'b0;
    u_tmw_cpu_model.rd(ADDR_CONTROL, b); check(b, 8'h00);
    u_tmw_cpu_model.rd(8'h80, b); check(b, 8'h00);
    $display("test reset done");
    u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h80);
    u_tmw_cpu_model.wr16(ADDR_COUNT_HIGH, ADDR_COUNT_LOW, 16'h01ff);
    cyc(2); check(count, 16'h01ff);
    u_tmw_cpu_model.wr(ADDR_COUNT_HIGH, 8'h77);
    cyc(2); check(count, 16'h01ff);
    u_tmw_cpu_model.rd16(ADDR_COUNT_LOW, ADDR_COUNT_HIGH, q); check(q, 16'h01ff);
    u_tmw_cpu_model.wr(ADDR_COUNT_HIGH, 8'h12);
    u_tmw_cpu_model.wr(ADDR_COUNT_LOW, 8'h34);
    u_tmw_cpu_model.wr(ADDR_COMPARE_FIRST, 8'h56);
    cyc(2); check(count, 16'h1234);
    u_tmw_cpu_model.wr(ADDR_COUNT_HIGH, 8'h99);
    u_tmw_cpu_model.rd(ADDR_COMPARE_SECOND, b); check(b, 8'h12);
    u_tmw_cpu_model.rd(ADDR_COMPARE_FIRST, b); check(b, 8'h56);
    u_tmw_cpu_model.rd(ADDR_COUNT_HIGH, b); check(b, 8'h99);
    $display("test wide access done");
    for (int i = 0; i < 2; i++) begin
      u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h80);
      u_tmw_cpu_model.wr(ADDR_FLAGS, 8'hff);
      u_tmw_cpu_model.wr16(ADDR_COUNT_HIGH, ADDR_COUNT_LOW, i ? 16'hfff0 : 16'h00f0);
      u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h81);
      cyc(24);
      check(count[15:8], i ? 8'h00 : 8'h01);
      check(ovf_f, i[0]);
    end
    // Prescaled starts may lag one period, hence the range
    for (int cs = 2; cs < 6; cs++) begin
      u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h00);
      u_tmw_cpu_model.wr(ADDR_COUNT_LOW, 8'h00);
      u_tmw_cpu_model.wr(ADDR_CONTROL, 8'(cs));
      cyc(6 * div[cs]);
      check(count >= 16'h4 && count <= 16'h6, 1'b1);
    end
    u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h01);
    u_tmw_cpu_model.wr(ADDR_FLAGS, 8'hff);
    cyc(300); check(ovf_f, 1'b1);
    u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h00);
    u_tmw_cpu_model.wr(ADDR_COUNT_LOW, 8'h5a);
    cyc(20); check(count, 16'h005a);
    $display("test clock select done");
    u_tmw_cpu_model.wr(ADDR_COMPARE_FIRST, 8'h05);
    u_tmw_cpu_model.wr(ADDR_COMPARE_SECOND, 8'h03);
    u_tmw_cpu_model.wr(ADDR_COUNT_LOW, 8'h00);
    u_tmw_cpu_model.wr(ADDR_FLAGS, 8'hff);
    u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h09);
    k = 0;
    repeat (40) begin
      cyc(1);
      if (count > 16'h5) k++;
    end
    check(k, 0);
    check(cmp1_f, 1'b1);
    check(cmp2_f, 1'b1);
    u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h00);
    u_tmw_cpu_model.wr(ADDR_COMPARE_FIRST, 8'h20);
    u_tmw_cpu_model.wr(ADDR_COUNT_LOW, 8'h00);
    u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h01);
    u_tmw_cpu_model.wr(ADDR_FLAGS, 8'hff);
    u_tmw_cpu_model.wr(ADDR_COUNT_LOW, 8'h20);
    cyc(6); check(cmp1_f, 1'b0);
    $display("test compare done");
    for (int e = 6; e < 8; e++) begin
      u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h00);
      u_tmw_cpu_model.wr(ADDR_COUNT_LOW, 8'h00);
      u_tmw_cpu_model.wr(ADDR_CONTROL, 8'(e));
      repeat (3) begin
        ext_pin = 1'b1;
        cyc(4);
        ext_pin = 1'b0;
        cyc(4);
      end
      cyc(4); check(count, 16'h0003);
    end
    $display("test external clock done");
    u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h00);
    u_tmw_cpu_model.wr(ADDR_COUNT_LOW, 8'h42);
    u_tmw_cpu_model.wr(ADDR_FLAGS, 8'hff);
    u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h50);
    cap_pin = 1'b1; cyc(6); check(cap_f, 1'b1);
    u_tmw_cpu_model.rd(ADDR_CAPTURE_LOW, b); check(b, 8'h42);
    u_tmw_cpu_model.wr(ADDR_FLAGS, 8'hff);
    cap_pin = 1'b0; cyc(8); check(cap_f, 1'b0);
    u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h40);
    cap_pin = 1'b1; cyc(8); check(cap_f, 1'b0);
    cap_pin = 1'b0; cyc(8); check(cap_f, 1'b1);
    u_tmw_cpu_model.wr(ADDR_FLAGS, 8'hff);
    u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h70);
    cap_pin = 1'b1; cyc(2); cap_pin = 1'b0; cyc(8); check(cap_f, 1'b0);
    cap_pin = 1'b1; cyc(8); check(cap_f, 1'b1);
    u_tmw_cpu_model.wr(ADDR_CONTROL, 8'h80);
    u_tmw_cpu_model.wr16(ADDR_COUNT_HIGH, ADDR_COUNT_LOW, 16'h1234);
    u_tmw_cpu_model.wr(ADDR_CONTROL, 8'hd0);
    cap_pin = 1'b0; cyc(8); cap_pin = 1'b1; cyc(8);
    u_tmw_cpu_model.wr(ADDR_CAPTURE_HIGH, 8'h77);
    u_tmw_cpu_model.rd16(ADDR_CAPTURE_LOW, ADDR_CAPTURE_HIGH, q); check(q, 16'h1234);
    $display("test capture done");
    report_and_stop();
  end
endmodule
bind tmw_timer tmw_timer_sva u_tmw_timer_sva (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
  .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .bus_write_in(bus_write_in),
  .bus_read_in(bus_read_in), .external_count_pin_in(external_count_pin_in),
  .bus_rdata_out(bus_rdata_out), .overflow_flag_out(overflow_flag_out), .count_out(count_out));

// [test/tmw_cpu_model.sv]
// CPU-side bus model issuing byte and wide register accesses.
`timescale 1ns/10ps
module tmw_cpu_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] bus_rdata_in,
  output logic [7:0] bus_addr_out,
  output logic [7:0] bus_wdata_out,
  output logic bus_write_out,
  output logic bus_read_out
);
  // ==========================================================
  // Access tasks, entered at a falling edge
  initial begin
    bus_addr_out = 8'h00;
    bus_wdata_out = 8'h00;
    bus_write_out = 1'b0;
    bus_read_out = 1'b0;
  end
  task automatic strobe(input logic wr, input logic [7:0] a, input logic [7:0] d);
    bus_addr_out = a;
    bus_wdata_out = d;
    bus_write_out = wr;
    bus_read_out = !wr;
    @(posedge sys_clk_in);
    @(negedge sys_clk_in);
  endtask
  // Idle bus shows inverted junk so stale values are never trusted
  task automatic idle();
    bus_write_out = 1'b0;
    bus_read_out = 1'b0;
    bus_addr_out = ~bus_addr_out;
    bus_wdata_out = ~bus_wdata_out;
    @(negedge sys_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    strobe(1'b1, a, d);
    idle();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    strobe(1'b0, a, 8'h00);
    q = bus_rdata_in;
    idle();
  endtask
  // Both halves back to back, so nothing can slip in and reuse the latch
  task automatic wr16(input logic [7:0] ahi, input logic [7:0] alo, input logic [15:0] v);
    strobe(1'b1, ahi, v[15:8]);
    strobe(1'b1, alo, v[7:0]);
    idle();
  endtask
  task automatic rd16(input logic [7:0] alo, input logic [7:0] ahi, output logic [15:0] q);
    strobe(1'b0, alo, 8'h00);
    q[7:0] = bus_rdata_in;
    strobe(1'b0, ahi, 8'h00);
    q[15:8] = bus_rdata_in;
    idle();
  endtask
endmodule

// [test/tmw_timer_sva.sv]
// Checker: port-level assertions for the wide timer.
`timescale 1ns/10ps
module tmw_timer_sva
  import tmw_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] bus_addr_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic bus_write_in,
  input wire logic bus_read_in,
  input wire logic external_count_pin_in,
  input wire logic [7:0] bus_rdata_out,
  input wire logic overflow_flag_out,
  input wire logic [15:0] count_out
);
  // ==========================================================
  // Helper state
  logic [7:0] ctrl;
  logic [2:0] quiet;
  logic [2:0] pin_quiet;
  logic pin_d;
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) ctrl <= RESET_BYTE;
    else if (bus_write_in && bus_addr_in == ADDR_CONTROL) ctrl <= bus_wdata_in;
  end
  // Any write may move the counter, so count checks wait for a quiet bus
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || bus_write_in) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  always_ff @(posedge sys_clk_in) begin
    pin_d <= external_count_pin_in;
    if (reset_in || pin_d != external_count_pin_in) pin_quiet <= 3'h0;
    else if (pin_quiet != 3'h7) pin_quiet <= pin_quiet + 3'h1;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // ==========================================================
  // Assertions
  a_rdata_idle_zero: assert property (!bus_read_in |=> bus_rdata_out == 8'h00)
    else $error("read data not zero while idle");
  a_unmapped_read_zero: assert property (bus_read_in && (bus_addr_in < 8'h1f ||
    bus_addr_in > 8'h27) |=> bus_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_control_readback: assert property (bus_read_in && !bus_write_in &&
    bus_addr_in == ADDR_CONTROL |=> bus_rdata_out == ctrl)
    else $error("control readback wrong");
  a_low_read_count: assert property (bus_read_in && bus_addr_in == ADDR_COUNT_LOW
    |=> bus_rdata_out == count_out[7:0])
    else $error("count low read wrong");
  a_high_after_low: assert property (bus_read_in && bus_addr_in == ADDR_COUNT_LOW ##1
    bus_read_in && bus_addr_in == ADDR_COUNT_HIGH |=> bus_rdata_out == $past(count_out[15:8]))
    else $error("high byte not staged by low read");
  a_stop_holds_count: assert property (ctrl[2:0] == 3'h0 && quiet >= 3'h3
    |=> $stable(count_out))
    else $error("stopped counter moved");
  a_div1_step_one: assert property (ctrl == 8'h01 && quiet >= 3'h3
    |=> count_out == {8'h00, $past(count_out[7:0]) + 8'h01})
    else $error("direct clock count step wrong");
  a_ext_pin_idle: assert property (ctrl[2:1] == 2'h3 && quiet >= 3'h3 &&
    pin_quiet >= 3'h4 |=> $stable(count_out))
    else $error("counter moved without pin edge");
  a_overflow_at_max: assert property (ctrl == 8'h01 && quiet >= 3'h3 &&
    count_out[7:0] == MAX_NARROW |-> ##[0:2] overflow_flag_out)
    else $error("overflow flag missing at wrap");
  c_wide_read: cover property (bus_read_in && bus_addr_in == ADDR_COUNT_LOW ##1
    bus_read_in && bus_addr_in == ADDR_COUNT_HIGH);
  c_overflow: cover property ($rose(overflow_flag_out));
  c_ext_count: cover property (ctrl[2:1] == 2'h3 && $changed(count_out));
endmodule
